// ---- rtl/tmr_regs.svh ----
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

// I/O register addresses (6-bit I/O space)
`define TMR_ADDR_CNT_L 6'h00
`define TMR_ADDR_CNT_H 6'h01
`define TMR_ADDR_CMPA_L 6'h02
`define TMR_ADDR_CMPA_H 6'h03
`define TMR_ADDR_CMPB_L 6'h04
`define TMR_ADDR_CMPB_H 6'h05
`define TMR_ADDR_CAP_L 6'h06
`define TMR_ADDR_CAP_H 6'h07
`define TMR_ADDR_CTRL_A 6'h08
`define TMR_ADDR_CTRL_B 6'h09
`define TMR_ADDR_FLAG 6'h0A
`define TMR_ADDR_MASK 6'h0B
`define TMR_ADDR_SFIO 6'h0C

// Field positions
`define TMR_SFIO_PSR_BIT 0
`define TMR_CTRLB_CS_MSB 2
`define TMR_CTRLB_CS_LSB 0
`define TMR_CTRLB_WGM_MSB 4
`define TMR_CTRLB_WGM_LSB 3
`define TMR_CTRLB_EDGE_BIT 6
`define TMR_CTRLB_FILT_BIT 7
`define TMR_CTRLA_WGM_MSB 1
`define TMR_CTRLA_WGM_LSB 0
`define TMR_CTRLA_COMB_MSB 5
`define TMR_CTRLA_COMB_LSB 4
`define TMR_CTRLA_COMA_MSB 7
`define TMR_CTRLA_COMA_LSB 6
`define TMR_FLAG_OVF 0
`define TMR_FLAG_CMPB 1
`define TMR_FLAG_CMPA 2
`define TMR_FLAG_CAP 3

// Reset values
`define TMR_REG8_RESET 8'h00
`define TMR_REG16_RESET 16'h0000
`define TMR_FLAGS_RESET 4'h0

// Counter landmarks
`define TMR_BOTTOM 16'h0000
`define TMR_MAX 16'hFFFF
`define TMR_TOP_8BIT 16'h00FF
`define TMR_TOP_9BIT 16'h01FF
`define TMR_TOP_10BIT 16'h03FF

// Timing counts
`define TMR_PRESC_WIDTH 10
`define TMR_DIV8_LAST 3'h7
`define TMR_DIV64_LAST 6'h3F
`define TMR_DIV256_LAST 8'hFF
`define TMR_DIV1024_LAST 10'h3FF
`define TMR_FILTER_LEN 4

`endif

// ---- rtl/tmr_pkg.sv ----
package tmr_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } tmr_io_req_type;

  typedef struct packed {
    logic div1024;
    logic div256;
    logic div64;
    logic div8;
  } tmr_taps_type;

  typedef enum logic [2:0] {
    TMR_CS_OFF = 3'h0,
    TMR_CS_SYS = 3'h1,
    TMR_CS_DIV8 = 3'h2,
    TMR_CS_DIV64 = 3'h3,
    TMR_CS_DIV256 = 3'h4,
    TMR_CS_DIV1024 = 3'h5,
    TMR_CS_EXT_FALL = 3'h6,
    TMR_CS_EXT_RISE = 3'h7
  } tmr_clksel_type;

  typedef enum logic [3:0] {
    TMR_WGM_NORMAL = 4'h0,
    TMR_WGM_CTC_A = 4'h4,
    TMR_WGM_FAST8 = 4'h5,
    TMR_WGM_FAST9 = 4'h6,
    TMR_WGM_FAST10 = 4'h7,
    TMR_WGM_CTC_CAP = 4'hC,
    TMR_WGM_FAST_CAP = 4'hE,
    TMR_WGM_FAST_A = 4'hF
  } tmr_wgm_type;

endpackage

// ---- rtl/tmr_prescaler.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tmr_regs.svh"

module tmr_prescaler (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clear,
  output tmr_pkg::tmr_taps_type taps
);

  logic [`TMR_PRESC_WIDTH-1:0] count;
  logic [`TMR_PRESC_WIDTH-1:0] next_count;

  // Free running, ignores clock select; only clear restarts it
  always_comb begin
    if (clear) begin
      next_count = '0;
    end else begin
      next_count = count + `TMR_PRESC_WIDTH'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Taps fire on the last cycle of each period, so a cleared divider gives a full period
  assign taps.div8 = (count[2:0] == `TMR_DIV8_LAST);
  assign taps.div64 = (count[5:0] == `TMR_DIV64_LAST);
  assign taps.div256 = (count[7:0] == `TMR_DIV256_LAST);
  assign taps.div1024 = (count == `TMR_DIV1024_LAST);

endmodule

`default_nettype wire

// ---- rtl/tmr_timer16.sv ----
// Overview of operation
// - Writing one to prescaler reset bit resets the shared prescaler.
// - Prescaler reset bit clears itself once the reset is done.
// - Writing zero to that bit does nothing; it always reads zero.
// - Prescaler reset changes tick timing of this timer and of the prescale_taps output.
// - Counter, compares, capture are 16 bits; control registers 8 bits, unrestricted.
// - Four interrupt flags in one flag register, each gated by mask bit.
// - Clock select picks prescaled or external edge source; none means idle.
// - Double-buffered compare registers compared continuously; match drives output pin.
// - Compare match on A or B sets that channel's flag.
// - Selected capture edge stores counter into capture register, optional filter.
// - Counter signals BOTTOM at 0x0000 and MAX at 0xFFFF.
// - TOP is 0x00FF, 0x01FF, 0x03FF, compare A or capture per mode.
// - Compare A as PWM TOP drives no PWM output and stays double buffered.
// - All 16-bit registers share one 8-bit high-byte holding register.
// - Low-byte write loads holding byte and written byte together.
// - Counter and capture low-byte reads copy high byte to holding; their high reads return holding.
// - Compare high-byte reads return the register directly, not holding.
// - Prescaled taps come from free-running prescaler; first tick within N+1.
`timescale 1ns/10ps
`default_nettype none
`include "tmr_regs.svh"

module tmr_timer16 (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire tmr_pkg::tmr_io_req_type io_req,
  output logic [7:0] io_rdata,
  input wire logic ext_count_pin,
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  input wire logic capture_from_comparator,
  input wire logic [3:0] irq_ack,
  output logic [3:0] irq_req,
  output logic compare_output_pin_a,
  output logic compare_output_pin_b,
  output tmr_pkg::tmr_taps_type prescale_taps,
  output logic at_bottom,
  output logic at_max,
  output logic at_top
);

  function automatic logic is_pwm(input logic [3:0] wgm);
    case (wgm)
      tmr_pkg::TMR_WGM_FAST8, tmr_pkg::TMR_WGM_FAST9, tmr_pkg::TMR_WGM_FAST10,
      tmr_pkg::TMR_WGM_FAST_CAP, tmr_pkg::TMR_WGM_FAST_A: is_pwm = 1'b1;
      default: is_pwm = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] wgm, input logic [15:0] cmpa,
                                         input logic [15:0] cap);
    case (wgm)
      tmr_pkg::TMR_WGM_FAST8: top_of = `TMR_TOP_8BIT;
      tmr_pkg::TMR_WGM_FAST9: top_of = `TMR_TOP_9BIT;
      tmr_pkg::TMR_WGM_FAST10: top_of = `TMR_TOP_10BIT;
      tmr_pkg::TMR_WGM_CTC_A, tmr_pkg::TMR_WGM_FAST_A: top_of = cmpa;
      tmr_pkg::TMR_WGM_CTC_CAP, tmr_pkg::TMR_WGM_FAST_CAP: top_of = cap;
      default: top_of = `TMR_MAX;
    endcase
  endfunction

  // Register state
  logic [15:0] counter_value;
  logic [15:0] compare_buf_a;
  logic [15:0] compare_reg_a;
  logic [15:0] compare_buf_b;
  logic [15:0] compare_reg_b;
  logic [15:0] capture_register;
  logic [7:0] hold_high;
  logic [7:0] timer_ctrl_a;
  logic [7:0] timer_ctrl_b;
  logic [3:0] timer_flag_reg;
  logic [3:0] timer_mask_reg;
  logic pin_a;
  logic pin_b;
  logic [7:0] rdata;
  logic psr_pulse;
  logic [15:0] next_counter_value;
  logic [15:0] next_compare_buf_a;
  logic [15:0] next_compare_reg_a;
  logic [15:0] next_compare_buf_b;
  logic [15:0] next_compare_reg_b;
  logic [15:0] next_capture_register;
  logic [7:0] next_hold_high;
  logic [7:0] next_timer_ctrl_a;
  logic [7:0] next_timer_ctrl_b;
  logic [3:0] next_timer_flag_reg;
  logic [3:0] next_timer_mask_reg;
  logic next_pin_a;
  logic next_pin_b;
  logic [7:0] next_rdata;
  logic next_psr_pulse;

  // Input sampling state
  logic ext_s1;
  logic ext_s2;
  logic ext_d;
  logic cap_s1;
  logic cap_s2;
  logic [`TMR_FILTER_LEN-1:0] cap_hist;
  logic cap_lvl;
  logic cap_prev;
  logic next_cap_lvl;
  logic [`TMR_FILTER_LEN-1:0] next_cap_hist;

  // Decoded controls
  logic [2:0] clk_sel;
  logic [3:0] wgm;
  logic [1:0] com_a;
  logic [1:0] com_b;
  logic pwm;
  logic [15:0] top;
  logic tick;
  logic wrap;
  logic match_a;
  logic match_b;
  logic cap_event;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;

  tmr_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clear(psr_pulse),
    .taps(prescale_taps)
  );

  assign clk_sel = timer_ctrl_b[`TMR_CTRLB_CS_MSB:`TMR_CTRLB_CS_LSB];
  assign wgm = {timer_ctrl_b[`TMR_CTRLB_WGM_MSB:`TMR_CTRLB_WGM_LSB],
                timer_ctrl_a[`TMR_CTRLA_WGM_MSB:`TMR_CTRLA_WGM_LSB]};
  assign com_a = timer_ctrl_a[`TMR_CTRLA_COMA_MSB:`TMR_CTRLA_COMA_LSB];
  assign com_b = timer_ctrl_a[`TMR_CTRLA_COMB_MSB:`TMR_CTRLA_COMB_LSB];
  assign pwm = is_pwm(wgm);
  assign top = top_of(wgm, compare_reg_a, capture_register);

  always_comb begin
    case (clk_sel)
      tmr_pkg::TMR_CS_OFF: tick = 1'b0;
      tmr_pkg::TMR_CS_SYS: tick = 1'b1;
      tmr_pkg::TMR_CS_DIV8: tick = prescale_taps.div8;
      tmr_pkg::TMR_CS_DIV64: tick = prescale_taps.div64;
      tmr_pkg::TMR_CS_DIV256: tick = prescale_taps.div256;
      tmr_pkg::TMR_CS_DIV1024: tick = prescale_taps.div1024;
      tmr_pkg::TMR_CS_EXT_FALL: tick = ext_d & ~ext_s2;
      tmr_pkg::TMR_CS_EXT_RISE: tick = ext_s2 & ~ext_d;
      default: tick = 1'b0;
    endcase
  end

  assign at_bottom = (counter_value == `TMR_BOTTOM);
  assign at_max = (counter_value == `TMR_MAX);
  assign at_top = (counter_value == top);
  assign wrap = tick & at_top;
  assign match_a = tick & (counter_value == compare_reg_a);
  assign match_b = tick & (counter_value == compare_reg_b);

  // Capture source: filter needs a stable run of samples before the level moves
  always_comb begin
    next_cap_hist = {cap_hist[`TMR_FILTER_LEN-2:0], cap_s2};
    next_cap_lvl = cap_lvl;
    if (!timer_ctrl_b[`TMR_CTRLB_FILT_BIT]) begin
      next_cap_lvl = cap_s2;
    end else if (&next_cap_hist) begin
      next_cap_lvl = 1'b1;
    end else if (~|next_cap_hist) begin
      next_cap_lvl = 1'b0;
    end
  end

  assign cap_event = timer_ctrl_b[`TMR_CTRLB_EDGE_BIT] ? (cap_lvl & ~cap_prev) : (~cap_lvl & cap_prev);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_d <= 1'b0;
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
      cap_hist <= '0;
      cap_lvl <= 1'b0;
      cap_prev <= 1'b0;
    end else begin
      ext_s1 <= ext_count_pin;
      ext_s2 <= ext_s1;
      ext_d <= ext_s2;
      cap_s1 <= capture_from_comparator ? comparator_out : capture_input_pin;
      cap_s2 <= cap_s1;
      cap_hist <= next_cap_hist;
      cap_lvl <= next_cap_lvl;
      cap_prev <= cap_lvl;
    end
  end

  always_comb begin
    flag_set = '0;
    flag_set[`TMR_FLAG_OVF] = pwm ? wrap : (tick & at_max);
    flag_set[`TMR_FLAG_CMPA] = match_a;
    flag_set[`TMR_FLAG_CMPB] = match_b;
    flag_set[`TMR_FLAG_CAP] = cap_event;
    flag_clr = irq_ack;
    if (io_req.wr && io_req.addr == `TMR_ADDR_FLAG) begin
      flag_clr = flag_clr | io_req.wdata[3:0];
    end
  end

  always_comb begin
    next_counter_value = counter_value;
    next_compare_buf_a = compare_buf_a;
    next_compare_reg_a = compare_reg_a;
    next_compare_buf_b = compare_buf_b;
    next_compare_reg_b = compare_reg_b;
    next_capture_register = capture_register;
    next_hold_high = hold_high;
    next_timer_ctrl_a = timer_ctrl_a;
    next_timer_ctrl_b = timer_ctrl_b;
    next_timer_mask_reg = timer_mask_reg;
    next_pin_a = pin_a;
    next_pin_b = pin_b;
    next_rdata = `TMR_REG8_RESET;
    next_psr_pulse = 1'b0;
    // Set wins over clear so an event in the clearing cycle is kept
    next_timer_flag_reg = (timer_flag_reg & ~flag_clr) | flag_set;
    if (tick) begin
      next_counter_value = at_top ? `TMR_BOTTOM : counter_value + 16'h0001;
    end
    // Buffered compare values take effect at the wrap in PWM modes only
    if (!pwm || wrap) begin
      next_compare_reg_a = compare_buf_a;
      next_compare_reg_b = compare_buf_b;
    end
    if (cap_event) begin
      next_capture_register = counter_value;
    end
    if (pwm) begin
      if (wgm != tmr_pkg::TMR_WGM_FAST_A && com_a[1]) begin
        if (match_a) next_pin_a = com_a[0];
        else if (wrap) next_pin_a = ~com_a[0];
      end
      if (com_b[1]) begin
        if (match_b) next_pin_b = com_b[0];
        else if (wrap) next_pin_b = ~com_b[0];
      end
    end else begin
      if (match_a) begin
        case (com_a)
          2'h1: next_pin_a = ~pin_a;
          2'h2: next_pin_a = 1'b0;
          2'h3: next_pin_a = 1'b1;
          default: next_pin_a = pin_a;
        endcase
      end
      if (match_b) begin
        case (com_b)
          2'h1: next_pin_b = ~pin_b;
          2'h2: next_pin_b = 1'b0;
          2'h3: next_pin_b = 1'b1;
          default: next_pin_b = pin_b;
        endcase
      end
    end
    // CPU writes override counting
    if (io_req.wr) begin
      case (io_req.addr)
        `TMR_ADDR_CNT_H, `TMR_ADDR_CMPA_H, `TMR_ADDR_CMPB_H, `TMR_ADDR_CAP_H: next_hold_high = io_req.wdata;
        `TMR_ADDR_CNT_L: next_counter_value = {hold_high, io_req.wdata};
        `TMR_ADDR_CMPA_L: next_compare_buf_a = {hold_high, io_req.wdata};
        `TMR_ADDR_CMPB_L: next_compare_buf_b = {hold_high, io_req.wdata};
        `TMR_ADDR_CAP_L: begin
          // Only meaningful when the capture register sets TOP
          if (wgm == tmr_pkg::TMR_WGM_CTC_CAP || wgm == tmr_pkg::TMR_WGM_FAST_CAP) begin
            next_capture_register = {hold_high, io_req.wdata};
          end
        end
        `TMR_ADDR_CTRL_A: next_timer_ctrl_a = io_req.wdata;
        `TMR_ADDR_CTRL_B: next_timer_ctrl_b = io_req.wdata;
        `TMR_ADDR_MASK: next_timer_mask_reg = io_req.wdata[3:0];
        `TMR_ADDR_SFIO: next_psr_pulse = io_req.wdata[`TMR_SFIO_PSR_BIT];
        default: next_hold_high = next_hold_high;
      endcase
    end
    if (io_req.rd) begin
      case (io_req.addr)
        `TMR_ADDR_CNT_L: begin
          next_rdata = counter_value[7:0];
          next_hold_high = counter_value[15:8];
        end
        `TMR_ADDR_CAP_L: begin
          next_rdata = capture_register[7:0];
          next_hold_high = capture_register[15:8];
        end
        `TMR_ADDR_CNT_H, `TMR_ADDR_CAP_H: next_rdata = hold_high;
        `TMR_ADDR_CMPA_L: next_rdata = compare_buf_a[7:0];
        `TMR_ADDR_CMPA_H: next_rdata = compare_buf_a[15:8];
        `TMR_ADDR_CMPB_L: next_rdata = compare_buf_b[7:0];
        `TMR_ADDR_CMPB_H: next_rdata = compare_buf_b[15:8];
        `TMR_ADDR_CTRL_A: next_rdata = timer_ctrl_a;
        `TMR_ADDR_CTRL_B: next_rdata = timer_ctrl_b;
        `TMR_ADDR_FLAG: next_rdata = {4'h0, timer_flag_reg};
        `TMR_ADDR_MASK: next_rdata = {4'h0, timer_mask_reg};
        `TMR_ADDR_SFIO: next_rdata = `TMR_REG8_RESET;
        default: next_rdata = `TMR_REG8_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      counter_value <= `TMR_REG16_RESET;
      compare_buf_a <= `TMR_REG16_RESET;
      compare_reg_a <= `TMR_REG16_RESET;
      compare_buf_b <= `TMR_REG16_RESET;
      compare_reg_b <= `TMR_REG16_RESET;
      capture_register <= `TMR_REG16_RESET;
      hold_high <= `TMR_REG8_RESET;
      timer_ctrl_a <= `TMR_REG8_RESET;
      timer_ctrl_b <= `TMR_REG8_RESET;
      timer_flag_reg <= `TMR_FLAGS_RESET;
      timer_mask_reg <= `TMR_FLAGS_RESET;
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      rdata <= `TMR_REG8_RESET;
      psr_pulse <= 1'b0;
    end else begin
      counter_value <= next_counter_value;
      compare_buf_a <= next_compare_buf_a;
      compare_reg_a <= next_compare_reg_a;
      compare_buf_b <= next_compare_buf_b;
      compare_reg_b <= next_compare_reg_b;
      capture_register <= next_capture_register;
      hold_high <= next_hold_high;
      timer_ctrl_a <= next_timer_ctrl_a;
      timer_ctrl_b <= next_timer_ctrl_b;
      timer_flag_reg <= next_timer_flag_reg;
      timer_mask_reg <= next_timer_mask_reg;
      pin_a <= next_pin_a;
      pin_b <= next_pin_b;
      rdata <= next_rdata;
      psr_pulse <= next_psr_pulse;
    end
  end

  assign io_rdata = rdata;
  assign irq_req = timer_flag_reg & timer_mask_reg;
  assign compare_output_pin_a = pin_a;
  assign compare_output_pin_b = pin_b;

endmodule

`default_nettype wire

// ---- verif/tmr_timer16_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tmr_regs.svh"

module tmr_timer16_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire tmr_pkg::tmr_io_req_type io_req,
  input wire logic [7:0] io_rdata,
  input wire logic [3:0] irq_req,
  input wire tmr_pkg::tmr_taps_type prescale_taps,
  input wire logic at_bottom,
  input wire logic at_max
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_sfio_zero;
    io_req.rd && io_req.addr == `TMR_ADDR_SFIO |=> io_rdata == 8'h00;
  endproperty
  a_sfio_zero: assert property (p_sfio_zero) else $error("prescaler control read nonzero");

  property p_rdata_idle;
    !io_req.rd |=> io_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");

  property p_psr_div8;
    io_req.wr && io_req.addr == `TMR_ADDR_SFIO && io_req.wdata[0] |=>
      ##1 !prescale_taps.div8 [*7] ##1 prescale_taps.div8;
  endproperty
  a_psr_div8: assert property (p_psr_div8) else $error("div8 tap not restarted");

  property p_psr_div64;
    io_req.wr && io_req.addr == `TMR_ADDR_SFIO && io_req.wdata[0] |-> ##65 prescale_taps.div64;
  endproperty
  a_psr_div64: assert property (p_psr_div64) else $error("div64 tap not restarted");

  property p_wr_bottom;
    (io_req.wr && io_req.addr == `TMR_ADDR_CNT_H) ##1 (io_req.wr && io_req.addr == `TMR_ADDR_CNT_L) |=>
      at_bottom == ({$past(io_req.wdata, 2), $past(io_req.wdata)} == 16'h0000);
  endproperty
  a_wr_bottom: assert property (p_wr_bottom) else $error("bottom wrong after counter write");

  property p_wr_max;
    (io_req.wr && io_req.addr == `TMR_ADDR_CNT_H) ##1 (io_req.wr && io_req.addr == `TMR_ADDR_CNT_L) |=>
      at_max == ({$past(io_req.wdata, 2), $past(io_req.wdata)} == 16'hFFFF);
  endproperty
  a_wr_max: assert property (p_wr_max) else $error("max wrong after counter write");

  property p_mask_gate;
    io_req.wr && io_req.addr == `TMR_ADDR_MASK && io_req.wdata[3:0] == 4'h0 |=> irq_req == 4'h0;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("request passes a cleared mask");

  property p_ctrl_rb;
    (io_req.wr && io_req.addr == `TMR_ADDR_CTRL_A) ##1 (io_req.rd && io_req.addr == `TMR_ADDR_CTRL_A) |=>
      (io_rdata & 8'hF3) == ($past(io_req.wdata, 2) & 8'hF3);
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control byte read back differs");

  property p_cmp_direct;
    (io_req.wr && io_req.addr == `TMR_ADDR_CMPA_H) ##1 (io_req.wr && io_req.addr == `TMR_ADDR_CMPA_L)
      ##1 (io_req.rd && io_req.addr == `TMR_ADDR_CNT_L) ##1 (io_req.rd && io_req.addr == `TMR_ADDR_CMPA_H)
      |=> io_rdata == $past(io_req.wdata, 4);
  endproperty
  a_cmp_direct: assert property (p_cmp_direct) else $error("compare high read used hold byte");
endmodule

bind tmr_timer16 tmr_timer16_checker u_checker (.clk_sys(clk_sys), .resetn(resetn), .io_req(io_req),
  .io_rdata(io_rdata), .irq_req(irq_req), .prescale_taps(prescale_taps), .at_bottom(at_bottom),
  .at_max(at_max));
`default_nettype wire

// ---- verif/tmr_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module tmr_cpu_model (
  input wire logic clk_sys,
  output var tmr_pkg::tmr_io_req_type io_req,
  input wire logic [7:0] io_rdata
);
  initial io_req = '0;

  // Strobe stays up until the next access or idle, so no signal is set twice in one step
  task automatic io_write(input logic [5:0] addr, input logic [7:0] data);
    io_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk_sys);
    #1;
  endtask

  task automatic io_read(input logic [5:0] addr, output logic [7:0] data);
    io_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk_sys);
    #1;
    data = io_rdata;
  endtask

  task automatic idle(input int n);
    io_req = '0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  // One caller at a time, so the hold byte is never disturbed mid-pair
  task automatic write16(input logic [5:0] lo, input logic [15:0] val);
    io_write(lo + 6'h01, val[15:8]);
    io_write(lo, val[7:0]);
  endtask

  task automatic read16(input logic [5:0] lo, output logic [15:0] val);
    io_read(lo, val[7:0]);
    io_read(lo + 6'h01, val[15:8]);
  endtask
endmodule
`default_nettype wire

// ---- verif/test_tmr_timer16.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tmr_regs.svh"

module test_tmr_timer16;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  tmr_pkg::tmr_io_req_type io_req;
  logic [7:0] io_rdata;
  logic ext_count_pin = 1'b0;
  logic capture_input_pin = 1'b0;
  logic comparator_out = 1'b0;
  logic capture_from_comparator = 1'b0;
  logic [3:0] irq_ack = 4'h0;
  logic [3:0] irq_req;
  tmr_pkg::tmr_taps_type prescale_taps;
  logic at_bottom;
  logic at_max;
  logic at_top;
  logic compare_output_pin_a;
  logic compare_output_pin_b;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] d;
  logic [15:0] w;

  always #10 clk_sys = ~clk_sys;

  tmr_timer16 uut (.clk_sys(clk_sys), .resetn(resetn), .io_req(io_req), .io_rdata(io_rdata),
    .ext_count_pin(ext_count_pin), .capture_input_pin(capture_input_pin), .comparator_out(comparator_out),
    .capture_from_comparator(capture_from_comparator), .irq_ack(irq_ack), .irq_req(irq_req),
    .compare_output_pin_a(compare_output_pin_a), .compare_output_pin_b(compare_output_pin_b),
    .prescale_taps(prescale_taps),
    .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top));

  tmr_cpu_model u_cpu (.clk_sys(clk_sys), .io_req(io_req), .io_rdata(io_rdata));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic t_regs();
    for (logic [5:0] a = `TMR_ADDR_CTRL_A; a <= `TMR_ADDR_SFIO; a++) begin
      u_cpu.io_read(a, d);
      check(16'(d), 16'h0000);
    end
    u_cpu.io_read(6'h3F, d);
    check(16'(d), 16'h0000);
    u_cpu.io_write(`TMR_ADDR_CTRL_A, 8'h50);
    u_cpu.io_read(`TMR_ADDR_CTRL_A, d);
    check(16'(d), 16'h0050);
    u_cpu.io_write(`TMR_ADDR_CTRL_A, 8'h00);
  endtask

  task automatic t_access16();
    u_cpu.write16(`TMR_ADDR_CNT_L, 16'h01FF);
    u_cpu.read16(`TMR_ADDR_CNT_L, w);
    check(w, 16'h01FF);
    u_cpu.io_write(`TMR_ADDR_CMPA_H, 8'hAB);
    u_cpu.io_write(`TMR_ADDR_CMPA_L, 8'h12);
    u_cpu.io_read(`TMR_ADDR_CNT_L, d);
    u_cpu.io_read(`TMR_ADDR_CMPA_H, d);
    check(16'(d), 16'h00AB);
    // Hold still carries the counter high byte from the low read
    u_cpu.io_write(`TMR_ADDR_CMPB_L, 8'h34);
    u_cpu.read16(`TMR_ADDR_CMPB_L, w);
    check(w, 16'h0134);
    u_cpu.write16(`TMR_ADDR_CNT_L, 16'hFFFF);
    check(16'(at_max), 16'h0001);
    u_cpu.write16(`TMR_ADDR_CNT_L, 16'h0000);
    check(16'({at_bottom, at_max}), 16'h0002);
  endtask

  task automatic t_psr();
    int n;
    int n8;
    n8 = 0;
    u_cpu.io_write(`TMR_ADDR_SFIO, 8'h00);
    u_cpu.io_write(`TMR_ADDR_SFIO, 8'h01);
    u_cpu.idle(0);
    for (n = 1; n < 300 && prescale_taps.div64 !== 1'b1; n++) begin
      if (prescale_taps.div8 === 1'b1 && n8 == 0)
        n8 = n;
      @(posedge clk_sys);
      #1;
    end
    check(16'(n8), 16'd9);
    check(16'(n), 16'd65);
    u_cpu.io_read(`TMR_ADDR_SFIO, d);
    check(16'(d), 16'h0000);
    // Cleared divider, then 64 cycles on the /8 tap give exactly eight ticks
    u_cpu.io_write(`TMR_ADDR_SFIO, 8'h01);
    u_cpu.io_write(`TMR_ADDR_CTRL_B, 8'h02);
    u_cpu.idle(64);
    u_cpu.io_write(`TMR_ADDR_CTRL_B, 8'h00);
    u_cpu.read16(`TMR_ADDR_CNT_L, w);
    check(w, 16'h0008);
  endtask

  task automatic t_overflow();
    u_cpu.write16(`TMR_ADDR_CNT_L, 16'hFFFD);
    u_cpu.io_write(`TMR_ADDR_FLAG, 8'h0F);
    u_cpu.io_write(`TMR_ADDR_MASK, 8'h01);
    u_cpu.io_write(`TMR_ADDR_CTRL_B, 8'h01);
    u_cpu.idle(6);
    u_cpu.io_write(`TMR_ADDR_CTRL_B, 8'h00);
    u_cpu.io_read(`TMR_ADDR_FLAG, d);
    check(16'(d & 8'h0F), 16'h0001);
    check(16'(irq_req), 16'h0001);
    u_cpu.idle(0);
    irq_ack = 4'h1;
    @(posedge clk_sys);
    #1;
    irq_ack = 4'h0;
    u_cpu.idle(1);
    check(16'(irq_req), 16'h0000);
    u_cpu.io_write(`TMR_ADDR_MASK, 8'h00);
  endtask

  task automatic t_compare();
    u_cpu.write16(`TMR_ADDR_CNT_L, 16'h0000);
    u_cpu.write16(`TMR_ADDR_CMPA_L, 16'h0010);
    u_cpu.write16(`TMR_ADDR_CMPB_L, 16'h0008);
    u_cpu.io_write(`TMR_ADDR_CTRL_A, 8'h70);
    u_cpu.io_write(`TMR_ADDR_FLAG, 8'h0F);
    u_cpu.io_write(`TMR_ADDR_CTRL_B, 8'h01);
    u_cpu.idle(30);
    u_cpu.io_write(`TMR_ADDR_CTRL_B, 8'h00);
    u_cpu.io_read(`TMR_ADDR_FLAG, d);
    check(16'(d & 8'h0F), 16'h0006);
    check(16'({compare_output_pin_a, compare_output_pin_b}), 16'h0003);
    // Vector acknowledge clears only its own flag
    irq_ack = 4'h4;
    u_cpu.idle(1);
    irq_ack = 4'h0;
    u_cpu.io_read(`TMR_ADDR_FLAG, d);
    check(16'(d & 8'h0F), 16'h0002);
    u_cpu.io_write(`TMR_ADDR_FLAG, 8'h02);
    u_cpu.io_read(`TMR_ADDR_FLAG, d);
    check(16'(d & 8'h0F), 16'h0000);
  endtask

  task automatic t_clksel();
    u_cpu.write16(`TMR_ADDR_CNT_L, 16'h0100);
    u_cpu.idle(10);
    u_cpu.read16(`TMR_ADDR_CNT_L, w);
    check(w, 16'h0100);
    // Rising then falling edge select, three pin pulses each
    for (int m = 7; m >= 6; m--) begin
      u_cpu.io_write(`TMR_ADDR_CTRL_B, 8'(m));
      u_cpu.idle(2);
      repeat (3) begin
        ext_count_pin = 1'b1;
        u_cpu.idle(4);
        ext_count_pin = 1'b0;
        u_cpu.idle(4);
      end
      u_cpu.io_write(`TMR_ADDR_CTRL_B, 8'h00);
      u_cpu.read16(`TMR_ADDR_CNT_L, w);
      check(w, 16'h0100 + 16'(3 * (8 - m)));
    end
  endtask

  task automatic t_capture();
    u_cpu.write16(`TMR_ADDR_CNT_L, 16'h1234);
    u_cpu.io_write(`TMR_ADDR_FLAG, 8'h0F);
    u_cpu.io_write(`TMR_ADDR_CTRL_B, 8'h40);
    u_cpu.idle(2);
    capture_input_pin = 1'b1;
    u_cpu.idle(8);
    u_cpu.read16(`TMR_ADDR_CAP_L, w);
    check(w, 16'h1234);
    u_cpu.io_read(`TMR_ADDR_FLAG, d);
    check(16'(d & 8'h0F), 16'h0008);
    u_cpu.write16(`TMR_ADDR_CNT_L, 16'h4321);
    u_cpu.io_write(`TMR_ADDR_FLAG, 8'h0F);
    // Filter on: the source switch and the new edge each need a settled run
    u_cpu.io_write(`TMR_ADDR_CTRL_B, 8'hC0);
    u_cpu.idle(0);
    capture_from_comparator = 1'b1;
    u_cpu.idle(8);
    comparator_out = 1'b1;
    u_cpu.idle(8);
    u_cpu.read16(`TMR_ADDR_CAP_L, w);
    check(w, 16'h4321);
    u_cpu.io_read(`TMR_ADDR_FLAG, d);
    check(16'(d & 8'h0F), 16'h0008);
    irq_ack = 4'h8;
    u_cpu.idle(1);
    irq_ack = 4'h0;
    u_cpu.io_read(`TMR_ADDR_FLAG, d);
    check(16'(d & 8'h0F), 16'h0000);
  endtask

  task automatic t_top();
    logic [3:0] m [5] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'hC};
    logic [15:0] t [5] = '{16'hFFFF, 16'h00FF, 16'h01FF, 16'h03FF, 16'h4321};
    for (int i = 0; i < 5; i++) begin
      u_cpu.io_write(`TMR_ADDR_CTRL_A, {6'h00, m[i][1:0]});
      u_cpu.io_write(`TMR_ADDR_CTRL_B, {3'h0, m[i][3:2], 3'h0});
      u_cpu.write16(`TMR_ADDR_CNT_L, t[i]);
      check(16'(at_top), 16'h0001);
      u_cpu.write16(`TMR_ADDR_CNT_L, t[i] - 16'h0001);
      check(16'(at_top), 16'h0000);
    end
    u_cpu.io_write(`TMR_ADDR_CTRL_B, 8'h00);
    u_cpu.io_write(`TMR_ADDR_CTRL_A, 8'h00);
    u_cpu.idle(0);
  endtask

  // Whole run needs about 400 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    t_regs();
    t_access16();
    t_psr();
    t_overflow();
    t_compare();
    t_clksel();
    t_capture();
    t_top();
    end_of_test();
  end
endmodule
`default_nettype wire
